/* File: rtl/ssir_params.svh */
// Register offsets, field positions and timing constants for the status and interrupt register bank
`ifndef SSIR_PARAMS_SVH
`define SSIR_PARAMS_SVH
`define SSIR_ADDR_STATUS 8'h04
`define SSIR_ADDR_TARGET 8'h04
`define SSIR_ADDR_REASON 8'h05
`define SSIR_ADDR_TIMEOUT 8'h05
`define SSIR_ADDR_SEQ 8'h06
`define SSIR_ADDR_CTRL1 8'h08
`define SSIR_ADDR_CLKCONV 8'h09
`define SSIR_ADDR_CTRL2 8'h0B
`define SSIR_BIT_RST_DIS 6
`define SSIR_BIT_LATCH 6
`define SSIR_BIT_BUS_RESET_SEEN 7
`define SSIR_BIT_BAD_COMMAND_FLAG 6
`define SSIR_BIT_DIS 5
`define SSIR_BIT_SR 4
`define SSIR_BIT_SO 3
`define SSIR_BIT_RESELECTED_FLAG 2
`define SSIR_BIT_SELECTED_ATTN_FLAG 1
`define SSIR_BIT_SEL 0
`define SSIR_BIT_INT 7
`define SSIR_TICKS_PER_UNIT 8192
`define SSIR_ZERO8 8'h00
`endif

/* File: rtl/ssir_pkg.sv */
// Types shared by the status and interrupt register bank
package ssir_pkg;
	// Host register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ssir_req_t;
	// Events reported by the sequencer and bus watchers
	typedef struct packed {
		logic busReset;
		logic badCommand;
		logic disconnect;
		logic serviceRequest;
		logic success;
		logic reselected;
		logic selectedAttn;
		logic selected;
	} ssir_evt_t;
	// Timer run states
	typedef enum logic [1:0] {TM_IDLE, TM_RUN, TM_EXPIRED} ssir_tstate_t;
endpackage

/* File: rtl/ssir_sync.sv */
// Three-stage synchroniser for pin-level inputs
`timescale 1ns/10ps
`default_nettype none
module ssir_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	// Stages; first stage only feeds second
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	// Shift chain
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	// Change accepted once second and third stages agree
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			dout <= '0;
		end else if (s2_q == s3_q) begin
			dout <= s3_q;
		end
	end
endmodule
`default_nettype wire

/* File: rtl/ssir_timer.sv */
// Selection timeout counter scaled by the clock factor
`timescale 1ns/10ps
`default_nettype none
`include "ssir_params.svh"
module ssir_timer #(
	parameter int PRESCALE = `SSIR_TICKS_PER_UNIT
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic abort,
	input wire logic [7:0] units,
	input wire logic [2:0] factor,
	output logic expired
);
	// Prescale counter, factor counter, unit counter
	logic [15:0] pre_q;
	logic [2:0] fac_q;
	logic [7:0] unit_q;
	ssir_pkg::ssir_tstate_t st_q;
	logic [2:0] facEff;
	// Factor zero is taken as eight, as a 3-bit field cannot say eight otherwise
	assign facEff = (factor == 3'h0) ? 3'h7 : factor - 3'h1;
	// value times prescale times factor
	// Count down PRESCALE*factor cycles per unit
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_q <= ssir_pkg::TM_IDLE;
			pre_q <= 16'h0000;
			fac_q <= 3'h0;
			unit_q <= 8'h00;
		end else begin
			case (st_q)
				ssir_pkg::TM_IDLE: begin
					if (start) begin
						pre_q <= 16'(PRESCALE - 1);
						fac_q <= facEff;
						unit_q <= units;
						st_q <= (units == 8'h00) ? ssir_pkg::TM_EXPIRED : ssir_pkg::TM_RUN;
					end
				end
				ssir_pkg::TM_RUN: begin
					if (abort) begin
						st_q <= ssir_pkg::TM_IDLE;
					end else if (pre_q != 16'h0000) begin
						pre_q <= pre_q - 16'h0001;
					end else if (fac_q != 3'h0) begin
						pre_q <= 16'(PRESCALE - 1);
						fac_q <= fac_q - 3'h1;
					end else if (unit_q > 8'h01) begin
						pre_q <= 16'(PRESCALE - 1);
						fac_q <= facEff;
						unit_q <= unit_q - 8'h01;
					end else begin
						st_q <= ssir_pkg::TM_EXPIRED;
					end
				end
				ssir_pkg::TM_EXPIRED: begin
					st_q <= ssir_pkg::TM_IDLE;
				end
				default: begin
					st_q <= ssir_pkg::TM_IDLE;
				end
			endcase
		end
	end
	// One-cycle expiry pulse
	assign expired = (st_q == ssir_pkg::TM_EXPIRED);
endmodule
`default_nettype wire

/* File: rtl/ssir_regs.sv */
// Status, interrupt reason, target ID, timeout and sequence state registers
`timescale 1ns/10ps
`default_nettype none
`include "ssir_params.svh"
module ssir_regs #(
	parameter int PRESCALE = `SSIR_TICKS_PER_UNIT
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire ssir_pkg::ssir_req_t busReq,
	output logic [7:0] rdata,
	input wire logic softReset,
	input wire ssir_pkg::ssir_evt_t evt,
	input wire logic commandEnd,
	input wire logic [2:0] scsiPhasePins,
	input wire logic scsiResetPin,
	input wire logic [2:0] stepValue,
	input wire logic stepLoad,
	input wire logic offsetAtMax,
	input wire logic selectStart,
	input wire logic selectDone,
	input wire logic [4:0] otherStatus,
	output logic selectTimeout,
	output logic [2:0] targetId,
	output logic irq
);
	// Control register one: only the reset-report disable bit lives here
	logic [7:0] ctrlOne_q;
	// Control register two: latch-phase option
	logic [7:0] ctrlTwo_q;
	// Clock conversion factor field
	logic [2:0] clockFactor_q;
	// Target ID, no reset on purpose
	logic [2:0] targetId_q;
	// Timeout value
	logic [7:0] selTimeout_q;
	// Interrupt reason byte
	logic [7:0] reason_q;
	logic [7:0] reason_d;
	// Interrupt flag of the main status register
	logic intFlag_q;
	// Latched phase and latch-closed flag
	logic [2:0] phaseLatch_q;
	logic latchClosed_q;
	// Sequence step field
	logic [2:0] seqStep_q;
	// Synchronised pins
	logic [2:0] livePhase;
	logic scsiResetSync;
	logic scsiResetPrev_q;
	logic busResetEdge;
	// Decoded accesses
	logic rdReason;
	logic rdStatus;
	logic rdSeq;
	logic clrAll;
	logic latchOn;
	logic [2:0] phaseShown;
	logic timerExpired;

	// Access decode helper
	function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] target);
		hit = strobe && (a == target);
	endfunction

	// Pin synchronisers for phase and bus reset
	ssir_sync #(.W(4)) u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.din({scsiResetPin, scsiPhasePins}),
		.dout({scsiResetSync, livePhase})
	);

	// Selection timer
	ssir_timer #(.PRESCALE(PRESCALE)) u_timer (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.start(selectStart),
		.abort(selectDone),
		.units(selTimeout_q),
		.factor(clockFactor_q),
		.expired(timerExpired)
	);

	assign rdReason = hit(busReq.rd, busReq.addr, `SSIR_ADDR_REASON);
	assign rdStatus = hit(busReq.rd, busReq.addr, `SSIR_ADDR_STATUS);
	assign rdSeq = hit(busReq.rd, busReq.addr, `SSIR_ADDR_SEQ);
	assign clrAll = rdReason;
	assign latchOn = ctrlTwo_q[`SSIR_BIT_LATCH];
	assign busResetEdge = scsiResetSync && !scsiResetPrev_q;
	assign selectTimeout = timerExpired;

	// Bus reset edge detector on the synchronised level
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			scsiResetPrev_q <= 1'b0;
		end else begin
			scsiResetPrev_q <= scsiResetSync;
		end
	end

	// Control registers; soft reset restores defaults
	always_ff @(posedge sys_clk) begin
		if (!rst_n || softReset) begin
			ctrlOne_q <= `SSIR_ZERO8;
			ctrlTwo_q <= `SSIR_ZERO8;
			clockFactor_q <= 3'h0;
		end else if (busReq.wr) begin
			if (busReq.addr == `SSIR_ADDR_CTRL1) begin
				ctrlOne_q <= busReq.wdata;
			end
			if (busReq.addr == `SSIR_ADDR_CTRL2) begin
				ctrlTwo_q <= busReq.wdata;
			end
			if (busReq.addr == `SSIR_ADDR_CLKCONV) begin
				clockFactor_q <= busReq.wdata[2:0];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (hit(busReq.wr, busReq.addr, `SSIR_ADDR_TARGET)) begin
			targetId_q <= busReq.wdata[2:0];
		end
	end
	assign targetId = targetId_q;

	// timeout value write; scaling lives in the timer
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			selTimeout_q <= `SSIR_ZERO8;
		end else if (hit(busReq.wr, busReq.addr, `SSIR_ADDR_TIMEOUT)) begin
			selTimeout_q <= busReq.wdata;
		end
	end

	// Reason bit set terms; a set in the clearing cycle wins
	always_comb begin
		reason_d = clrAll ? `SSIR_ZERO8 : reason_q;
		if ((evt.busReset || busResetEdge) && !ctrlOne_q[`SSIR_BIT_RST_DIS]) begin
			reason_d[`SSIR_BIT_BUS_RESET_SEEN] = 1'b1;
		end
		if (evt.badCommand) begin
			reason_d[`SSIR_BIT_BAD_COMMAND_FLAG] = 1'b1;
		end
		if (evt.disconnect || timerExpired) begin
			reason_d[`SSIR_BIT_DIS] = 1'b1;
		end
		if (evt.serviceRequest) begin
			reason_d[`SSIR_BIT_SR] = 1'b1;
		end
		if (evt.success) begin
			reason_d[`SSIR_BIT_SO] = 1'b1;
		end
		if (evt.reselected) begin
			reason_d[`SSIR_BIT_RESELECTED_FLAG] = 1'b1;
		end
		if (evt.selectedAttn) begin
			reason_d[`SSIR_BIT_SELECTED_ATTN_FLAG] = 1'b1;
		end
		if (evt.selected) begin
			reason_d[`SSIR_BIT_SEL] = 1'b1;
		end
	end

	// Reason register
	always_ff @(posedge sys_clk) begin
		if (!rst_n || softReset) begin
			reason_q <= `SSIR_ZERO8;
		end else begin
			reason_q <= reason_d;
		end
	end

	// interrupt held while any reason bit set
	// reason read drops flag unless new event
	always_ff @(posedge sys_clk) begin
		if (!rst_n || softReset) begin
			intFlag_q <= 1'b0;
		end else begin
			intFlag_q <= (reason_d != `SSIR_ZERO8);
		end
	end
	assign irq = intFlag_q;

	// latch at command end, reopen on reason read
	always_ff @(posedge sys_clk) begin
		if (!rst_n || softReset) begin
			latchClosed_q <= 1'b0;
			phaseLatch_q <= 3'h0;
		end else if (commandEnd) begin
			latchClosed_q <= 1'b1;
			phaseLatch_q <= livePhase;
		end else if (clrAll) begin
			latchClosed_q <= 1'b0;
		end
	end

	// live phase when unlatched or latch open
	assign phaseShown = (latchOn && latchClosed_q) ? phaseLatch_q : livePhase;

	always_ff @(posedge sys_clk) begin
		if (!rst_n || softReset) begin
			seqStep_q <= 3'h0;
		end else if (stepLoad) begin
			seqStep_q <= stepValue;
		end else if (clrAll) begin
			seqStep_q <= 3'h0;
		end
	end

	// Read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdata <= `SSIR_ZERO8;
		end else if (rdStatus) begin
			// Flag on top, four loose status bits, then the phase; exactly eight bits
			rdata <= {intFlag_q, otherStatus[3:0], phaseShown};
		end else if (rdReason) begin
			rdata <= reason_q;
		end else if (rdSeq) begin
			rdata <= {4'h0, !offsetAtMax, seqStep_q};
		end else begin
			rdata <= `SSIR_ZERO8;
		end
	end
endmodule
`default_nettype wire

/* File: tb/ssir_regs_assertions.sv */
// Assertions for the status and interrupt register bank
`timescale 1ns/10ps
`default_nettype none
module ssir_regs_assertions (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire ssir_pkg::ssir_req_t busReq,
	input wire logic [7:0] rdata,
	input wire logic softReset,
	input wire ssir_pkg::ssir_evt_t evt,
	input wire logic stepLoad,
	input wire logic offsetAtMax,
	input wire logic [2:0] targetId,
	input wire logic irq
);
	// One clock domain, reset mutes all
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Decoded host strobes
	logic rdRsn, rdSeq, wrId;
	assign rdRsn = busReq.rd && busReq.addr == 8'h05;
	assign rdSeq = busReq.rd && busReq.addr == 8'h06;
	assign wrId = busReq.wr && busReq.addr == 8'h04;
	a_event_sets_irq: assert property (evt[6:0] != 7'h00 && !softReset |=> irq)
		else $error("irq not raised by event");
	a_read_drops_irq: assert property (rdRsn && evt == 8'h00 && !softReset |=> !irq)
		else $error("irq kept after reason read");
	a_irq_holds: assert property (irq && !rdRsn && !softReset |=> irq)
		else $error("irq dropped early");
	a_status_int: assert property (busReq.rd && busReq.addr == 8'h04 |=> rdata[7] == $past(irq))
		else $error("status int bit wrong");
	a_seq_reserved: assert property (rdSeq && $stable(offsetAtMax) |=> rdata[7:3] == {4'h0, !$past(offsetAtMax)})
		else $error("sequence upper bits wrong");
	a_id_write: assert property (wrId |=> targetId == $past(busReq.wdata[2:0]))
		else $error("target id not loaded");
	a_id_hold: assert property (wrId ##1 !wrId |=> targetId == $past(busReq.wdata[2:0], 2))
		else $error("target id not held");
	a_reason_clears: assert property (rdRsn && !stepLoad ##1 rdSeq && !stepLoad |=> rdata[2:0] == 3'h0)
		else $error("step not cleared");
	// Main scenarios reached
	c_reason_read: cover property (rdRsn && irq);
	c_id_write: cover property (wrId);
	c_clear_seq: cover property (rdRsn ##1 rdSeq);
endmodule
`default_nettype wire

/* File: tb/ssir_scsi_model.sv */
// Far-side bus model driving phase and reset lines
`timescale 1ns/10ps
`default_nettype none
module ssir_scsi_model (
	input wire logic [2:0] phaseReq,
	input wire logic rstReq,
	output logic [2:0] phasePins,
	output logic resetPin
);
	// Lines move off the clock, so the synchroniser is exercised
	// Continuous drive, so the lines hold a known level from 7 ns (phase) and 9 ns (reset) on
	assign #7 phasePins = phaseReq;
	assign #9 resetPin = rstReq;
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking testbench for the register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int PS = 4; // Short prescale keeps runs brief
	logic sys_clk, rst_n, softReset, commandEnd, stepLoad, offsetAtMax, selectStart, selectDone, rstReq;
	ssir_pkg::ssir_req_t busReq;
	ssir_pkg::ssir_evt_t evt;
	logic [7:0] rdata, d;
	logic [2:0] phasePins, phaseReq, stepValue, targetId, p;
	logic resetPin, selectTimeout, irq, rdPend;
	logic [15:0] expQ[$]; // Mask above, value below
	int errors, total_checks, n;
	ssir_regs #(.PRESCALE(PS)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .busReq(busReq), .rdata(rdata),
		.softReset(softReset), .evt(evt), .commandEnd(commandEnd), .scsiPhasePins(phasePins),
		.scsiResetPin(resetPin), .stepValue(stepValue), .stepLoad(stepLoad), .offsetAtMax(offsetAtMax),
		.selectStart(selectStart), .selectDone(selectDone), .otherStatus(5'h00),
		.selectTimeout(selectTimeout), .targetId(targetId), .irq(irq));
	ssir_scsi_model u_scsi (.phaseReq(phaseReq), .rstReq(rstReq), .phasePins(phasePins), .resetPin(resetPin));
	// 40 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Masked byte compare
	task automatic check8(input string s, input logic [7:0] e, input logic [7:0] g, input logic [7:0] m);
		total_checks++;
		if ((g & m) !== e) begin
			errors++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic wrap_up;
		if (errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Idle cycles, strobes dropped
	task automatic cyc(input int k);
		repeat (k) begin
			@(posedge sys_clk);
			busReq <= '0;
		end
	endtask
	// Strobes stay up for back-to-back use
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		busReq <= '{a, v, 1'b1, 1'b0};
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		expQ.push_back({m, e});
		@(posedge sys_clk);
		busReq <= '{a, 8'h00, 1'b0, 1'b1};
	endtask
	task automatic pulse(input ssir_pkg::ssir_evt_t v);
		@(posedge sys_clk);
		busReq <= '0;
		evt <= v;
		@(posedge sys_clk);
		evt <= '0;
	endtask
	// Read data monitor, settled half a cycle on
	always @(negedge sys_clk) begin
		if (rdPend) begin
			check8("rdata", expQ[0][7:0], rdata, expQ[0][15:8]);
			void'(expQ.pop_front());
		end
		rdPend = busReq.rd;
	end
	initial begin
		void'($urandom(32'h92E98F6F));
		rst_n = 1'b0;
		busReq = '0;
		evt = '0;
		softReset = 1'b0;
		commandEnd = 1'b0;
		stepLoad = 1'b0;
		stepValue = 3'h0;
		offsetAtMax = 1'b0;
		selectStart = 1'b0;
		selectDone = 1'b0;
		phaseReq = 3'h0;
		rstReq = 1'b0;
		rdPend = 1'b0;
		errors = 0;
		total_checks = 0;
		cyc(16);
		rst_n <= 1'b1;
		rd(8'h04, 8'h00, 8'h80);
		d = 8'($urandom);
		wr(8'h04, d);
		cyc(2);
		check8("targetId", {5'h00, d[2:0]}, targetId, 8'hFF);
		// Both resets must leave the ID alone
		rst_n <= 1'b0;
		cyc(3);
		rst_n <= 1'b1;
		softReset <= 1'b1;
		cyc(2);
		softReset <= 1'b0;
		cyc(2);
		check8("targetId", {5'h00, d[2:0]}, targetId, 8'hFF);
		for (int i = 0; i < 7; i++) begin
			pulse(ssir_pkg::ssir_evt_t'(8'h01 << i));
			#1 check8("irq", 8'h01, irq, 8'hFF);
			rd(8'h04, 8'h80, 8'h80);
			rd(8'h05, 8'h01 << i, 8'hFF);
			rd(8'h05, 8'h00, 8'hFF);
			cyc(1);
			#1 check8("irq", 8'h00, irq, 8'hFF);
		end
		// Bus reset reported, then masked
		for (int j = 0; j < 2; j++) begin
			wr(8'h08, j ? 8'h40 : 8'h00);
			cyc(1);
			rstReq <= 1'b1;
			cyc(4);
			rstReq <= 1'b0;
			cyc(10);
			rd(8'h05, j ? 8'h00 : 8'h80, 8'hFF);
		end
		// Step load with success, then cleared by reason read
		cyc(1);
		offsetAtMax <= 1'b1;
		stepValue <= 3'h4;
		stepLoad <= 1'b1;
		evt <= 8'h08;
		cyc(1);
		stepLoad <= 1'b0;
		evt <= '0;
		cyc(2);
		rd(8'h06, 8'h04, 8'hFF);
		rd(8'h05, 8'h08, 8'hFF);
		rd(8'h06, 8'h00, 8'h07);
		offsetAtMax <= 1'b0;
		cyc(3);
		rd(8'h06, 8'h08, 8'hF8);
		// Live phase, then latched at command end
		p = 3'($urandom);
		phaseReq <= p;
		cyc(8);
		rd(8'h04, {5'h00, p}, 8'h07);
		wr(8'h0B, 8'h40);
		cyc(1);
		commandEnd <= 1'b1;
		cyc(1);
		commandEnd <= 1'b0;
		phaseReq <= ~p;
		cyc(8);
		rd(8'h04, {5'h00, p}, 8'h07);
		rd(8'h05, 8'h00, 8'hFF);
		cyc(8);
		rd(8'h04, {5'h00, ~p}, 8'h07);
		wr(8'h0B, 8'h00);
		// Timeout of 3 units at factor 2
		wr(8'h09, 8'h02);
		wr(8'h05, 8'h03); // short stand-in for the 250 ms value, prescale shrunk
		cyc(1);
		// Aborted run must not report a timeout
		selectStart <= 1'b1;
		cyc(1);
		selectStart <= 1'b0;
		selectDone <= 1'b1;
		cyc(1);
		selectDone <= 1'b0;
		cyc(30);
		rd(8'h05, 8'h00, 8'h20);
		selectStart <= 1'b1;
		cyc(1);
		selectStart <= 1'b0;
		n = 0;
		while (selectTimeout !== 1'b1 && n < 100) begin
			@(negedge sys_clk);
			n++;
		end
		check8("timeout", 8'h01, 8'(n >= 3 * PS * 2 - 2 && n <= 3 * PS * 2 + 3), 8'hFF);
		cyc(2);
		rd(8'h05, 8'h20, 8'h20);
		cyc(4);
		wrap_up();
	end
endmodule
bind ssir_regs ssir_regs_assertions u_chk (.sys_clk, .rst_n, .busReq, .rdata, .softReset, .evt, .stepLoad,
	.offsetAtMax, .targetId, .irq);
`default_nettype wire
